// ---- core/demp_pkg.sv ----
// Purpose: constants and types for the dual external memory port
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes: all pin-level strobes and selects are active low
package demp_pkg;
  localparam int PA_W = 24;
  localparam int PD_W = 48;
  localparam int PS_N = 2;
  localparam int PW_LO = 16;
  localparam int DA_W = 32;
  localparam int DD_W = 40;
  localparam int DS_N = 4;
  localparam int DW_LO = 8;
  localparam int WORD_W = 32;
  localparam int PG_W_P = 8;
  localparam int PG_W_D = 8;
  typedef enum logic [1:0] {DEMP_IDLE, DEMP_BUSY, DEMP_DONE} demp_state_t;
endpackage

// ---- core/demp_port.sv ----
// Purpose: one external memory port: strobes, selects, waits, float, page
// Assumes: requests held until done pulses; bank table static
// Notes: used once per memory space with different widths
`timescale 1ns/100ps
module demp_port #(
  parameter int AW = 24,
  parameter int DW = 48,
  parameter int NS = 2,
  parameter int WLO = 16,
  parameter int PGW = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic req,
  input wire logic req_wr,
  input wire logic req_word,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  input wire logic [NS*AW-1:0] bank_base,
  input wire logic [PGW-1:0] page_bits,
  output logic done,
  output logic [DW-1:0] rdata,
  output logic [AW-1:0] addr_o,
  output logic addr_oe_n,
  output logic [DW-1:0] data_o,
  output logic data_oe_n,
  input wire logic [DW-1:0] data_i,
  output logic [NS-1:0] sel_n,
  output logic rd_n,
  output logic wr_n,
  output logic ctl_oe_n,
  input wire logic ack_in,
  output logic page_n,
  input wire logic float_n
);
  import demp_pkg::*;
  demp_state_t state_reg;
  logic [AW-1:0] last_reg;
  logic last_vld_reg;
  logic page_reg;
  logic [NS-1:0] sel_next;
  logic [AW-1:0] msk;
  logic floated;

  assign floated = !float_n;
  // page_bits counts the low in-page bits; the mask keeps only the bits above them
  assign msk = {AW{1'b1}} << page_bits;

  // bank select decode: highest-numbered bank whose base is not above the address wins
  always_comb begin
    sel_next = '0;
    for (int i = 0; i < NS; i++) begin
      if (req_addr >= bank_base[i*AW +: AW]) begin
        sel_next = '0;
        sel_next[i] = 1'b1;
      end
    end
  end

  // access sequencing with waits and float hold
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= DEMP_IDLE;
    end else begin
      unique case (state_reg)
        DEMP_IDLE: begin
          if (req) begin
            state_reg <= DEMP_BUSY;
          end
        end
        DEMP_BUSY: begin
          if (ack_in && !floated) begin
            state_reg <= DEMP_DONE;
          end
        end
        DEMP_DONE: begin
          state_reg <= DEMP_IDLE;
        end
        default: begin
          state_reg <= DEMP_IDLE;
        end
      endcase
    end
  end

  assign done = (state_reg == DEMP_DONE);

  // address and pin drive registered at start
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_o <= '0;
      data_o <= '0;
      sel_n <= '1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end else if (state_reg == DEMP_IDLE && req) begin
      addr_o <= req_addr;
      data_o <= req_word ? {req_wdata[WORD_W-1:0], {WLO{1'b0}}} : req_wdata;
      sel_n <= ~sel_next;
      rd_n <= req_wr;
      wr_n <= !req_wr;
    end else if (state_reg == DEMP_BUSY && ack_in && !floated) begin
      sel_n <= '1;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
    end
  end

  // read data taken with the acknowledge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (state_reg == DEMP_BUSY && ack_in && !floated && !rd_n) begin
      rdata <= data_i;
    end
  end

  // page crossing against the previous access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_reg <= '0;
      last_vld_reg <= 1'b0;
      page_reg <= 1'b0;
    end else if (state_reg == DEMP_IDLE && req) begin
      last_reg <= req_addr;
      last_vld_reg <= 1'b1;
      page_reg <= last_vld_reg && ((req_addr & msk) != (last_reg & msk));
    end else if (state_reg == DEMP_DONE) begin
      page_reg <= 1'b0;
    end
  end

  assign page_n = !page_reg;
  assign addr_oe_n = floated;
  assign ctl_oe_n = floated;
  assign data_oe_n = floated || (state_reg != DEMP_BUSY) || wr_n;

  AST_STROBE_EXCL: assert property (@(posedge clk) disable iff (sys_rst)
    !(!rd_n && !wr_n)) else $error("read and write strobes together");
  AST_WAIT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == DEMP_BUSY && !ack_in) |=> state_reg == DEMP_BUSY)
    else $error("access ended without acknowledge");
  AST_FLOAT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == DEMP_BUSY && floated) |=> !done) else $error("access ended while floated");
  AST_FLOAT_PINS: assert property (@(posedge clk) disable iff (sys_rst)
    floated |-> (addr_oe_n && ctl_oe_n && data_oe_n)) else $error("pins driven while floated");
  AST_ONE_SEL: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == DEMP_BUSY |-> $onehot(~sel_n)) else $error("select not one-hot");
  AST_SEL_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
    done |=> (sel_n == '1 && rd_n && wr_n)) else $error("strobes left asserted");
  AST_START: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == DEMP_IDLE && req) |=> (addr_o == $past(req_addr) && state_reg == DEMP_BUSY))
    else $error("address not presented");
  AST_WR_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    (state_reg == DEMP_BUSY && !wr_n && !floated) |-> !data_oe_n)
    else $error("write data not driven");
  AST_DONE_PULSE: assert property (@(posedge clk) disable iff (sys_rst)
    done |=> !done) else $error("done longer than a cycle");
  COV_READ: cover property (@(posedge clk) disable iff (sys_rst) !rd_n ##1 done);
  COV_WAIT: cover property (@(posedge clk) state_reg == DEMP_BUSY && !ack_in ##1 ack_in);
  COV_FLOAT: cover property (@(posedge clk) state_reg == DEMP_BUSY && floated ##1 !floated);
  COV_PAGE: cover property (@(posedge clk) !page_n);
endmodule

// ---- core/demp_top.sv ----
// Purpose: program and data external memory ports of the processor
// Assumes: core requests held until done; pins synchronous to clk
// Notes: each port floats independently of the other
`timescale 1ns/100ps
module demp_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic prog_req,
  input wire logic prog_req_wr,
  input wire logic prog_req_word,
  input wire logic [demp_pkg::PA_W-1:0] prog_req_addr,
  input wire logic [demp_pkg::PD_W-1:0] prog_req_wdata,
  input wire logic [demp_pkg::PS_N*demp_pkg::PA_W-1:0] prog_bank_base,
  input wire logic [demp_pkg::PG_W_P-1:0] prog_page_bits,
  output logic prog_done,
  output logic [demp_pkg::PD_W-1:0] prog_rdata,
  output logic [demp_pkg::PA_W-1:0] prog_addr_bus_o,
  output logic prog_addr_oe_n,
  output logic [demp_pkg::PD_W-1:0] prog_data_bus_o,
  output logic prog_data_oe_n,
  input wire logic [demp_pkg::PD_W-1:0] prog_data_bus_i,
  output logic [demp_pkg::PS_N-1:0] prog_bank_sel_n,
  output logic prog_read_strobe_n,
  output logic prog_write_strobe_n,
  output logic prog_ctl_oe_n,
  input wire logic prog_ack_in,
  output logic prog_page_cross_n,
  input wire logic prog_float_ctl_n,
  input wire logic data_req,
  input wire logic data_req_wr,
  input wire logic data_req_word,
  input wire logic [demp_pkg::DA_W-1:0] data_req_addr,
  input wire logic [demp_pkg::DD_W-1:0] data_req_wdata,
  input wire logic [demp_pkg::DS_N*demp_pkg::DA_W-1:0] data_bank_base,
  input wire logic [demp_pkg::PG_W_D-1:0] data_page_bits,
  output logic data_done,
  output logic [demp_pkg::DD_W-1:0] data_rdata,
  output logic [demp_pkg::DA_W-1:0] data_addr_bus_o,
  output logic data_addr_oe_n,
  output logic [demp_pkg::DD_W-1:0] data_data_bus_o,
  output logic data_data_oe_n,
  input wire logic [demp_pkg::DD_W-1:0] data_data_bus_i,
  output logic [demp_pkg::DS_N-1:0] data_bank_sel_n,
  output logic data_read_strobe_n,
  output logic data_write_strobe_n,
  output logic data_ctl_oe_n,
  input wire logic data_ack_in,
  output logic data_page_cross_n,
  input wire logic data_float_ctl_n
);
  import demp_pkg::*;

  demp_port #(.AW(PA_W), .DW(PD_W), .NS(PS_N), .WLO(PW_LO), .PGW(PG_W_P)) u_prog (
    .clk(clk), .sys_rst(sys_rst), .req(prog_req), .req_wr(prog_req_wr),
    .req_word(prog_req_word), .req_addr(prog_req_addr), .req_wdata(prog_req_wdata),
    .bank_base(prog_bank_base), .page_bits(prog_page_bits), .done(prog_done),
    .rdata(prog_rdata), .addr_o(prog_addr_bus_o), .addr_oe_n(prog_addr_oe_n),
    .data_o(prog_data_bus_o), .data_oe_n(prog_data_oe_n), .data_i(prog_data_bus_i),
    .sel_n(prog_bank_sel_n), .rd_n(prog_read_strobe_n), .wr_n(prog_write_strobe_n),
    .ctl_oe_n(prog_ctl_oe_n), .ack_in(prog_ack_in), .page_n(prog_page_cross_n),
    .float_n(prog_float_ctl_n)
  );

  demp_port #(.AW(DA_W), .DW(DD_W), .NS(DS_N), .WLO(DW_LO), .PGW(PG_W_D)) u_data (
    .clk(clk), .sys_rst(sys_rst), .req(data_req), .req_wr(data_req_wr),
    .req_word(data_req_word), .req_addr(data_req_addr), .req_wdata(data_req_wdata),
    .bank_base(data_bank_base), .page_bits(data_page_bits), .done(data_done),
    .rdata(data_rdata), .addr_o(data_addr_bus_o), .addr_oe_n(data_addr_oe_n),
    .data_o(data_data_bus_o), .data_oe_n(data_data_oe_n), .data_i(data_data_bus_i),
    .sel_n(data_bank_sel_n), .rd_n(data_read_strobe_n), .wr_n(data_write_strobe_n),
    .ctl_oe_n(data_ctl_oe_n), .ack_in(data_ack_in), .page_n(data_page_cross_n),
    .float_n(data_float_ctl_n)
  );
endmodule

// ---- testbench/demp_mem.sv ----
// Purpose: far-side memory bank model for one port
// Assumes: strobes active low, ack high means ready
// Notes: holds one word; idle read lines toggle so stale data never matches
`timescale 1ns/100ps
module demp_mem #(
  parameter int DW = 48
) (
  input wire logic clk,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ctl_oe_n,
  input wire logic doe_n,
  input wire logic [DW-1:0] wdata,
  input wire logic [3:0] waits,
  output logic [DW-1:0] rdata,
  output logic ack
);
  logic [DW-1:0] mem_reg;
  logic [DW-1:0] last_reg = '0;
  logic [3:0] cnt_reg;
  logic act;
  assign act = !ctl_oe_n && !(rd_n && wr_n);
  // wait states, then ack; ack high outside a live access
  assign ack = !act || cnt_reg >= waits;
  assign rdata = (act && !rd_n) ? mem_reg : ~last_reg;
  always_ff @(posedge clk) begin
    cnt_reg <= act ? cnt_reg + 4'h1 : 4'h0;
    last_reg <= rdata;
    if (act && !wr_n && !doe_n && ack) begin
      mem_reg <= wdata;
    end
  end
endmodule

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for the dual external memory port
// Assumes: one partner model per port answers the strobes
// Notes: inputs change on the falling edge only
`timescale 1ns/100ps
module tb;
  import demp_pkg::*;
  logic clk = 0;
  logic sys_rst, prog_req, prog_req_wr, prog_req_word, prog_done, prog_addr_oe_n;
  logic prog_data_oe_n, prog_read_strobe_n, prog_write_strobe_n, prog_ctl_oe_n;
  logic prog_ack_in, prog_page_cross_n, prog_float_ctl_n;
  logic data_req, data_req_wr, data_req_word, data_done, data_addr_oe_n, data_data_oe_n;
  logic data_read_strobe_n, data_write_strobe_n, data_ctl_oe_n, data_ack_in;
  logic data_page_cross_n, data_float_ctl_n;
  logic [PA_W-1:0] prog_req_addr, prog_addr_bus_o;
  logic [PD_W-1:0] prog_req_wdata, prog_rdata, prog_data_bus_o, prog_data_bus_i, pm_rd;
  logic [PS_N*PA_W-1:0] prog_bank_base;
  logic [PS_N-1:0] prog_bank_sel_n;
  logic [DA_W-1:0] data_req_addr, data_addr_bus_o;
  logic [DD_W-1:0] data_req_wdata, data_rdata, data_data_bus_o, data_data_bus_i, dm_rd;
  logic [DS_N*DA_W-1:0] data_bank_base;
  logic [DS_N-1:0] data_bank_sel_n;
  logic [7:0] prog_page_bits, data_page_bits;
  logic [3:0] p_waits, d_waits;
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  demp_top dut (.*);
  // pin level resolved from the port's data enable only
  assign prog_data_bus_i = prog_data_oe_n ? pm_rd : prog_data_bus_o;
  assign data_data_bus_i = data_data_oe_n ? dm_rd : data_data_bus_o;
  demp_mem #(.DW(PD_W)) pmem (.clk(clk), .rd_n(prog_read_strobe_n),
    .wr_n(prog_write_strobe_n), .ctl_oe_n(prog_ctl_oe_n), .doe_n(prog_data_oe_n),
    .wdata(prog_data_bus_i), .waits(p_waits), .rdata(pm_rd), .ack(prog_ack_in));
  demp_mem #(.DW(DD_W)) dmem (.clk(clk), .rd_n(data_read_strobe_n),
    .wr_n(data_write_strobe_n), .ctl_oe_n(data_ctl_oe_n), .doe_n(data_data_oe_n),
    .wdata(data_data_bus_i), .waits(d_waits), .rdata(dm_rd), .ack(data_ack_in));
  always #50 clk = ~clk;
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard: whole run needs well under 200 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 500) begin
      bad_count++;
      close_out();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic dp, input logic wr, input logic [31:0] a,
                     input logic [31:0] w, input logic [3:0] wt, input logic [3:0] sel,
                     input logic pg);
    int n;
    n = 0;
    if (dp) {data_req, data_req_wr, data_req_addr, data_req_wdata, d_waits} =
      {1'h1, wr, a, 8'h00, w, wt};
    else {prog_req, prog_req_wr, prog_req_addr, prog_req_wdata, p_waits} =
      {1'h1, wr, a[23:0], 16'h0000, w, wt};
    @(negedge clk);
    if (dp) chk({data_addr_bus_o, data_bank_sel_n, data_read_strobe_n, data_write_strobe_n,
      data_page_cross_n}, {a, sel, wr, !wr, pg});
    if (!dp) chk({prog_addr_bus_o, prog_bank_sel_n, prog_read_strobe_n, prog_write_strobe_n,
      prog_page_cross_n}, {a[23:0], sel[1:0], wr, !wr, pg});
    if (wr && dp) chk({data_data_oe_n, data_data_bus_o}, {1'h0, w, 8'h00});
    if (wr && !dp) chk({prog_data_oe_n, prog_data_bus_o}, {1'h0, w, 16'h0000});
    while ((dp ? data_done : prog_done) !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(n, wt + 1);
    if (!wr && dp) chk(data_rdata, {w, 8'h00});
    if (!wr && !dp) chk(prog_rdata, {w, 16'h0000});
    data_req = 0;
    prog_req = 0;
    @(negedge clk);
  endtask
  task automatic t_float();
    int n;
    n = 0;
    {prog_req, prog_req_wr, prog_req_addr, p_waits} = {2'h2, 24'h000130, 4'h0};
    {data_req, data_req_wr, data_req_addr, d_waits} = {2'h2, 32'h0000_0104, 4'h0};
    @(negedge clk);
    // float raised only inside a live access
    prog_float_ctl_n = 0;
    @(negedge clk);
    chk({data_done, data_ctl_oe_n}, 2'h2);
    data_req = 0;
    repeat (3) begin
      @(negedge clk);
      chk({prog_done, prog_ctl_oe_n, prog_addr_oe_n, prog_data_oe_n}, 4'h7);
    end
    prog_float_ctl_n = 1;
    while (prog_done !== 1'h1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk({n < 8, prog_rdata}, {1'h1, 32'hA5C3_9E17, 16'h0000});
    prog_req = 0;
    @(negedge clk);
  endtask
  task automatic t_dfloat();
    int n;
    n = 0;
    {data_req, data_req_wr, data_req_addr, d_waits} = {2'h2, 32'h4000_0008, 4'h0};
    @(negedge clk);
    // float raised only inside a live access
    data_float_ctl_n = 0;
    repeat (2) begin
      @(negedge clk);
      chk({data_done, data_ctl_oe_n, data_addr_oe_n, data_data_oe_n}, 4'h7);
    end
    data_float_ctl_n = 1;
    while (data_done !== 1'h1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk({n < 8, data_rdata}, {1'h1, 32'h3C5A_F00D, 8'h00});
    data_req = 0;
    @(negedge clk);
  endtask
  initial begin
    {sys_rst, prog_req, prog_req_wr, prog_req_word, prog_float_ctl_n} = 5'h13;
    {data_req, data_req_wr, data_req_word, data_float_ctl_n} = 4'h3;
    {prog_req_addr, prog_req_wdata, p_waits, data_req_addr, data_req_wdata, d_waits} = '0;
    prog_bank_base = {24'h800000, 24'h000000};
    data_bank_base = {32'hC000_0000, 32'h8000_0000, 32'h4000_0000, 32'h0000_0000};
    {prog_page_bits, data_page_bits} = {8'h08, 8'h08};
    repeat (3) @(negedge clk);
    sys_rst = 0;
    acc(0, 1, 32'h0080_0010, 32'hA5C3_9E17, 4'h2, 4'h1, 1);
    acc(0, 0, 32'h0080_0010, 32'hA5C3_9E17, 4'h0, 4'h1, 1);
    acc(0, 0, 32'h0000_0110, 32'hA5C3_9E17, 4'h1, 4'h2, 0);
    acc(0, 0, 32'h0000_0210, 32'hA5C3_9E17, 4'h0, 4'h2, 0);
    acc(1, 1, 32'h8000_0044, 32'h3C5A_F00D, 4'h1, 4'hB, 1);
    acc(1, 0, 32'hC000_0044, 32'h3C5A_F00D, 4'h0, 4'h7, 0);
    acc(1, 0, 32'h0000_0100, 32'h3C5A_F00D, 4'h2, 4'hE, 0);
    t_float();
    t_dfloat();
    close_out();
  end
endmodule
